// File: rtl/wdtw_top.v
// Windowed watchdog timer with an AHB-Lite register slave.
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module wdtw_top (
   input wire REF_CLK, // 50 MHz system clock.
   input wire RST, // Device reset, synchronous, active high.
   input wire HSEL, // Slave select.
   input wire [31:0] HADDR, // Byte address.
   input wire [1:0] HTRANS, // Transfer type.
   input wire HWRITE, // Write when high.
   input wire [2:0] HSIZE, // Transfer size.
   input wire [31:0] HWDATA, // Write data.
   input wire HREADY, // Bus ready.
   output reg [31:0] HRDATA, // Read data.
   output reg HREADYOUT, // Slave ready.
   output reg HRESP, // Always OKAY.
   output reg WDT_RESET_REQ, // One-cycle device reset request.
   output reg WDT_WAKE, // One-cycle wake-up pulse.
   output reg RC_OSC_EN, // Low-power RC oscillator enable.
   output reg LOW_POWER // Core in sleep or idle.
);
`include "wdtw_defs.vh"

   ////////////////////////////////////////////////////////////////////
   // Bus slave.
   localparam ST_IDLE = 2'b01;
   localparam ST_DATA = 2'b10;
   reg [1:0] bus_state_reg;
   reg [7:0] addr_reg;
   reg wr_reg;
   reg [6:0] cfg_reg;
   reg sw_en_reg;
   reg to_flag_reg;
   reg sleep_reg;
   reg idle_reg;
   reg [6:0] pre_reg;
   reg [14:0] post_reg;
   reg wake_cause_reg;
   reg [2:0] sw_sync_reg;

   wire take = HSEL && HREADY && HTRANS[1];
   wire wr_now = (bus_state_reg == ST_DATA) && wr_reg;
   wire reset_control_register_wr = wr_now && (addr_reg == `WDTW_ADDR_RESET_CONTROL_REGISTER);
   wire cfg_wr = wr_now && (addr_reg == `WDTW_ADDR_CFG);
   wire cmd_wr = wr_now && (addr_reg == `WDTW_ADDR_CMD);
   wire cmd_clear = cmd_wr && HWDATA[`WDTW_CMD_CLEAR];
   wire cmd_sleep = cmd_wr && HWDATA[`WDTW_CMD_SLEEP];
   wire cmd_idle = cmd_wr && HWDATA[`WDTW_CMD_IDLE];
   wire cmd_switch = cmd_wr && HWDATA[`WDTW_CMD_SWITCH];

   always @(posedge REF_CLK) begin
      if (RST) begin
         bus_state_reg <= ST_IDLE;
         addr_reg <= 8'h00;
         wr_reg <= 1'b0;
      end else begin
         case (bus_state_reg)
            ST_IDLE: begin
               if (take) begin
                  bus_state_reg <= ST_DATA;
                  addr_reg <= HADDR[7:0];
                  wr_reg <= HWRITE;
               end
            end
            ST_DATA: begin
               if (take) begin
                  addr_reg <= HADDR[7:0];
                  wr_reg <= HWRITE;
               end else begin
                  bus_state_reg <= ST_IDLE;
               end
            end
            default: begin
               bus_state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Enable, clock source and prescale selection.
   wire hw_en = cfg_reg[`WDTW_CFG_HWEN];
   wire wdt_en = hw_en || sw_en_reg;
   wire win_mode = !cfg_reg[`WDTW_CFG_WATCHDOG_WINDOW_DISABLE];
   wire low_pwr = sleep_reg || idle_reg;
   wire [6:0] pre_max = cfg_reg[`WDTW_CFG_PRE] ? `WDTW_PRE_LONG :
      `WDTW_PRE_SHORT;
   wire [3:0] post_sel = cfg_reg[`WDTW_CFG_POST_HI:`WDTW_CFG_POST_LO];
   // The postscale limit is 2^code - 1, so 1111 gives 1:32768.
   wire [15:0] post_lim16 = (16'h0001 << post_sel) - 16'h0001;
   wire [14:0] post_max = post_lim16[14:0];
   // The window opens once three quarters of the period have passed.
   wire [16:0] period = {1'b0, post_lim16} + 17'h00001;
   // The quarter is rounded up so that a 1:1 postscale leaves the whole
   // period open and a clear there is never early.
   wire [16:0] win_open = period - ((period + 17'h00003) >> 2);
   wire early = {2'b00, post_reg} < win_open;

   wire rc_tick;
   wdtw_tick u_tick (
      .clk(REF_CLK),
      .rst(RST),
      .run(wdt_en),
      .tick(rc_tick)
   );

   ////////////////////////////////////////////////////////////////////
   // Counting, clears and time-out.
   wire pre_end = rc_tick && (pre_reg == pre_max);
   wire expire = wdt_en && pre_end && (post_reg == post_max);
   wire leave = low_pwr && expire;
   wire bad_clear = cmd_clear && !low_pwr && wdt_en && win_mode &&
      early;
   wire trip = (expire && !low_pwr) || bad_clear;
   // Any clear event wins over the count step in the same cycle.
   // Expiry restarts the count so the next period is whole again.
   wire zero = cmd_clear || cmd_sleep || cmd_idle || cmd_switch ||
      expire || !wdt_en;

   always @(posedge REF_CLK) begin
      if (RST) begin
         pre_reg <= 7'h00;
         post_reg <= 15'h0000;
      end else if (zero) begin
         pre_reg <= 7'h00;
         post_reg <= 15'h0000;
      end else if (rc_tick) begin
         if (pre_end) begin
            pre_reg <= 7'h00;
            post_reg <= post_reg + 15'h0001;
         end else begin
            pre_reg <= pre_reg + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Reset-control, configuration and power state.
   always @(posedge REF_CLK) begin
      if (RST) begin
         cfg_reg <= `WDTW_CFG_RESET;
         sw_en_reg <= 1'b0;
         sleep_reg <= 1'b0;
         idle_reg <= 1'b0;
         wake_cause_reg <= 1'b0;
      end else begin
         if (cfg_wr) begin
            cfg_reg <= HWDATA[6:0];
         end
         if (reset_control_register_wr) begin
            sw_en_reg <= HWDATA[`WDTW_RC_SWEN];
         end
         // Status bits stay set across a watchdog wake.
         if (cmd_sleep) begin
            sleep_reg <= 1'b1;
         end else if (reset_control_register_wr && !HWDATA[`WDTW_RC_SLEEP]) begin
            sleep_reg <= 1'b0;
         end
         if (cmd_idle) begin
            idle_reg <= 1'b1;
         end else if (reset_control_register_wr && !HWDATA[`WDTW_RC_IDLE]) begin
            idle_reg <= 1'b0;
         end
         if (cmd_sleep || cmd_idle) begin
            wake_cause_reg <= 1'b1;
         end else if (leave) begin
            wake_cause_reg <= 1'b0;
         end
      end
   end

   // The time-out flag survives the reset it causes; only the first reset after power-up or a software write clears it.
   reg por_done_reg = 1'b0;
   always @(posedge REF_CLK) begin
      if (RST && !por_done_reg) begin
         to_flag_reg <= 1'b0;
      end else if (trip || leave) begin
         to_flag_reg <= 1'b1;
      end else if (reset_control_register_wr && !HWDATA[`WDTW_RC_TIMEOUT]) begin
         to_flag_reg <= 1'b0;
      end
   end

   always @(posedge REF_CLK) begin
      if (RST) begin
         por_done_reg <= 1'b1;
      end
   end

   // Watchdog enable (hardware or software) delayed three stages; RC_OSC_EN turns on at once and stays on until the delayed copy drops.
   always @(posedge REF_CLK) begin
      if (RST) begin
         sw_sync_reg <= 3'b000;
      end else begin
         sw_sync_reg <= {sw_sync_reg[1:0], wdt_en};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs and read data.
   wire [31:0] reset_control_register_val = {26'h0000000, sw_en_reg, to_flag_reg,
      sleep_reg, idle_reg, 2'b00};
   wire [31:0] stat_val = {9'h000, post_reg, 6'h00, low_pwr, wdt_en};
   reg [31:0] rd_mux;
   always @* begin
      case (HADDR[7:0])
         `WDTW_ADDR_RESET_CONTROL_REGISTER: rd_mux = reset_control_register_val;
         `WDTW_ADDR_CFG: rd_mux = {25'h0000000, cfg_reg};
         `WDTW_ADDR_STAT: rd_mux = stat_val;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge REF_CLK) begin
      if (RST) begin
         HRDATA <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         WDT_RESET_REQ <= 1'b0;
         WDT_WAKE <= 1'b0;
         RC_OSC_EN <= 1'b0;
         LOW_POWER <= 1'b0;
      end else begin
         if (take && !HWRITE) begin
            HRDATA <= rd_mux;
         end
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         WDT_RESET_REQ <= trip;
         WDT_WAKE <= leave;
         RC_OSC_EN <= wdt_en || sw_sync_reg[2];
         LOW_POWER <= wake_cause_reg && !leave;
      end
   end
endmodule

// File: rtl/wdtw_defs.vh
// Constants and register layout of the windowed watchdog timer.
// Notes on behaviour
// - Watchdog counts ticks of the low-power RC clock, nominally 32 kHz.
// - An enabled watchdog also keeps its RC clock source enabled.
// - Prescaler divides the source by 32 or by 128 per select bit.
// - Prescaler period is nominally 1 ms or 4 ms at 32 kHz.
// - Config bits 3:0 select one of 16 postscale ratios, 1:1 to 1:32768.
// - Any device reset clears counter, prescaler and postscaler.
// - A completed clock switch clears counter, prescaler and postscaler.
// - Entering or leaving sleep or idle clears all watchdog counts.
// - The clear instruction in normal execution clears all watchdog counts.
// - Enabled watchdog runs in sleep and idle; time-out wakes the core.
// - Sleep and idle status bits stay set after wake; software clears them.
// - Hardware enable bit set keeps the watchdog always enabled.
// - With hardware enable clear, the software enable bit 5 gates it.
// - Every device reset clears the software enable bit.
// - In window mode a clear before the last quarter causes a reset.
// - Time-out sets flag bit 4; only software clears it. The code also clears it on the first reset after power-up.
// - Prescale select 1 means divide by 128, 0 means divide by 32.
// - Postscale code 1111 is 1:32768, each step down halves the ratio.
// - Window-disable 1 selects normal mode, 0 selects window mode.
`ifndef WDTW_DEFS_VH
`define WDTW_DEFS_VH

`define WDTW_REF_CLK_HZ 50000000
`define WDTW_RC_HZ 32000
`define WDTW_PRE_SHORT 7'h1F
`define WDTW_PRE_LONG 7'h7F
`define WDTW_POST_W 4
`define WDTW_POST_CNT_W 15

// Register byte addresses.
`define WDTW_ADDR_RESET_CONTROL_REGISTER 8'h00
`define WDTW_ADDR_CFG 8'h04
`define WDTW_ADDR_CMD 8'h08
`define WDTW_ADDR_STAT 8'h0C

// Reset-control register fields.
`define WDTW_RC_IDLE 2
`define WDTW_RC_SLEEP 3
`define WDTW_RC_TIMEOUT 4
`define WDTW_RC_SWEN 5

// Configuration word fields.
`define WDTW_CFG_POST_HI 3
`define WDTW_CFG_POST_LO 0
`define WDTW_CFG_PRE 4
`define WDTW_CFG_HWEN 5
`define WDTW_CFG_WATCHDOG_WINDOW_DISABLE 6
`define WDTW_CFG_RESET 7'h7F

// Command register bits, write one to act.
`define WDTW_CMD_CLEAR 0
`define WDTW_CMD_SLEEP 1
`define WDTW_CMD_IDLE 2
`define WDTW_CMD_SWITCH 3

// Status register fields.
`define WDTW_ST_RUN 0
`define WDTW_ST_LOWPWR 1
`define WDTW_ST_POST_LO 8
`define WDTW_ST_POST_HI 22

`endif

// File: rtl/wdtw_tick.v
// Fractional divider that makes the 32 kHz low-power RC tick from REF_CLK.
`timescale 1ns/1ps
module wdtw_tick (
   input wire clk, // System clock.
   input wire rst, // Synchronous reset.
   input wire run, // Oscillator enabled.
   output reg tick // One-cycle RC tick.
);
`include "wdtw_defs.vh"
   // An accumulator keeps the mean rate exact without a second clock.
   reg [25:0] acc_reg;
   reg [25:0] acc_next;
   localparam [25:0] STEP = `WDTW_RC_HZ;
   localparam [25:0] LIMIT = `WDTW_REF_CLK_HZ;

   always @* begin
      acc_next = acc_reg + STEP;
      if (!run) begin
         acc_next = 26'h0000000;
      end else if (acc_next >= LIMIT) begin
         acc_next = acc_next - LIMIT;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         acc_reg <= 26'h0000000;
         tick <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         tick <= run && (acc_reg + STEP >= LIMIT);
      end
   end
endmodule

// File: testbench/wdtw_chk.sv
// Concurrent checks on the ports of the windowed watchdog.
`timescale 1ns/1ps
module wdtw_chk (
   input wire logic REF_CLK, // Clock.
   input wire logic RST, // Reset.
   input wire logic HSEL, // Select.
   input wire logic [31:0] HADDR, // Address.
   input wire logic [1:0] HTRANS, // Transfer.
   input wire logic HWRITE, // Write.
   input wire logic [31:0] HWDATA, // Write data.
   input wire logic HREADY, // Bus ready.
   input wire logic [31:0] HRDATA, // Read data.
   input wire logic HREADYOUT, // Slave ready.
   input wire logic HRESP, // Response.
   input wire logic WDT_RESET_REQ, // Reset request.
   input wire logic WDT_WAKE, // Wake pulse.
   input wire logic RC_OSC_EN, // RC enable.
   input wire logic LOW_POWER // Low power.
);
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////
   sequence s_cmd_addr;
      HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == 32'h0000_0008;
   endsequence
   sequence s_sleep_cmd;
      s_cmd_addr ##1 HWDATA[1];
   endsequence
   property p_bus_ok;
      HREADYOUT && !HRESP;
   endproperty
   a_bus_ok: assert property (p_bus_ok)
      else $error("Bus not ready or not OKAY.");
   property p_sleep_entry;
      s_sleep_cmd |=> ##1 LOW_POWER;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("Sleep command ignored.");
   property p_wake_pulse;
      WDT_WAKE |=> !WDT_WAKE;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("Wake pulse too long.");
   property p_req_pulse;
      WDT_RESET_REQ |=> !WDT_RESET_REQ;
   endproperty
   a_req_pulse: assert property (p_req_pulse)
      else $error("Reset request too long.");
   property p_wake_from_lp;
      WDT_WAKE |-> $past(LOW_POWER);
   endproperty
   a_wake_from_lp: assert property (p_wake_from_lp)
      else $error("Wake outside low power.");
   property p_wake_exit;
      WDT_WAKE |-> ##[0:1] !LOW_POWER;
   endproperty
   a_wake_exit: assert property (p_wake_exit)
      else $error("Low power not left on wake.");
   property p_req_needs_osc;
      WDT_RESET_REQ |-> $past(RC_OSC_EN);
   endproperty
   a_req_needs_osc: assert property (p_req_needs_osc)
      else $error("Reset request with RC stopped.");
   property p_no_req_in_lp;
      LOW_POWER && $past(LOW_POWER) |-> !WDT_RESET_REQ;
   endproperty
   a_no_req_in_lp: assert property (p_no_req_in_lp)
      else $error("Reset request in low power.");
   property p_reset_quiet;
      $past(RST) |-> !WDT_RESET_REQ && !WDT_WAKE && !LOW_POWER
         && HRDATA == 32'h0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("Outputs active after reset.");
endmodule
bind wdtw_top wdtw_chk wdtw_chk_i (.REF_CLK, .RST, .HSEL, .HADDR, .HTRANS,
   .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .WDT_RESET_REQ,
   .WDT_WAKE, .RC_OSC_EN, .LOW_POWER);

// File: testbench/wdtw_tb_top.sv
// Self-checking bench for the windowed watchdog timer.
`timescale 1ns/1ps
module wdtw_tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic hready = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   wire [31:0] hrdata;
   wire hreadyout, hresp, req, wake, osc_en, low_power;
   int err_count = 0;
   int checks_done = 0;
   always #10 ref_clk = ~ref_clk;
   wdtw_top wdtw_top_i (.REF_CLK(ref_clk), .RST(rst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .WDT_RESET_REQ(req),
      .WDT_WAKE(wake), .RC_OSC_EN(osc_en), .LOW_POWER(low_power));
   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task summarize;
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task edge_rdy;
      int k;
      @(posedge ref_clk);
      for (k = 0; k < 16 && hreadyout !== 1'b1; k++)
         @(posedge ref_clk);
      if (k == 16) begin
         chk(32'h0, 32'h1);
         summarize;
      end
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      edge_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy;
      rd = hrdata;
   endtask
   task rdchk(input logic [31:0] a, input logic [31:0] m,
         input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task wait_evt(input logic use_wake, output int cyc);
      for (cyc = 0; cyc < 60000; cyc++) begin
         @(posedge ref_clk);
         if ((use_wake ? wake : req) === 1'b1)
            break;
      end
      if (cyc == 60000) begin
         chk(32'h0, 32'h1);
         summarize;
      end
   endtask
   ////////////////////////////////////////////////////////////
   task t_reset_values;
      rdchk(32'h04, 32'hFFFFFFFF, 32'h0000007F);
      rdchk(32'h00, 32'hFFFFFFFF, 32'h0);
      rdchk(32'h0C, 32'h1, 32'h1);
      chk(32'(osc_en), 32'h1);
      rdchk(32'h10, 32'hFFFFFFFF, 32'h0);
   endtask
   task t_sw_enable;
      xfer(1'b1, 32'h04, 32'h40);
      rdchk(32'h04, 32'hFFFFFFFF, 32'h40);
      rdchk(32'h0C, 32'h1, 32'h0);
      repeat (5) @(posedge ref_clk);
      chk(32'(osc_en), 32'h0);
      xfer(1'b1, 32'h00, 32'h20);
      rdchk(32'h0C, 32'h1, 32'h1);
      chk(32'(osc_en), 32'h1);
   endtask
   // The RC tick divider keeps its phase across clears, so the period
   // bounds allow one tick of slack on either side of 32 ticks.
   task t_sleep_wake;
      int c;
      xfer(1'b1, 32'h08, 32'h2);
      rdchk(32'h00, 32'h2C, 32'h28);
      chk(32'(low_power), 32'h1);
      wait_evt(1'b1, c);
      chk(32'(c >= 48000 && c <= 52000), 32'h1);
      @(posedge ref_clk);
      chk(32'(low_power), 32'h0);
      rdchk(32'h00, 32'h2C, 32'h28);
      xfer(1'b1, 32'h00, 32'h20);
      rdchk(32'h00, 32'hFFFFFFFF, 32'h20);
   endtask
   task t_run_timeout;
      int c;
      wait_evt(1'b0, c);
      chk(32'(c >= 47800 && c <= 52000), 32'h1);
      rdchk(32'h00, 32'hFFFFFFFF, 32'h30);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rdchk(32'h00, 32'hFFFFFFFF, 32'h10);
      xfer(1'b1, 32'h00, 32'h0);
      rdchk(32'h00, 32'hFFFFFFFF, 32'h0);
      rdchk(32'h0C, 32'h1, 32'h1);
   endtask
   // A 1:1 postscale leaves the whole period open; 1:2 refuses an
   // immediate clear with a reset request.
   task t_window;
      xfer(1'b1, 32'h00, 32'h20);
      xfer(1'b1, 32'h04, 32'h00);
      xfer(1'b1, 32'h08, 32'h01);
      #1;
      chk(32'(req), 32'h0);
      xfer(1'b1, 32'h04, 32'h01);
      xfer(1'b1, 32'h08, 32'h01);
      #1;
      chk(32'(req), 32'h1);
      rdchk(32'h00, 32'h10, 32'h10);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset_values;
      t_sw_enable;
      t_sleep_wake;
      t_run_timeout;
      t_window;
      summarize;
   end
endmodule
